// file: verilog/rtpc_tx_ctrl.sv
// Transmit control: payload limit, MAC mode, transmit queue, retries and status.
//
// Our own choices: the address map and register access over AHB-Lite.
`include "rtpc_params.svh"
module rtpc_tx_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic rf_start,
   output logic rf_tag,
   output logic rf_ack_req,
   output logic rf_app_hdr,
   output logic rf_bcast,
   output logic rf_dest_long,
   output logic rf_encrypt,
   output logic [7:0] rf_len,
   input wire logic rf_done,
   input wire logic rf_done_tag,
   input wire logic [1:0] rf_result,
   output logic dup_detect_en,
   output logic txs_valid,
   output logic [7:0] txs_frame_id,
   output logic [7:0] txs_code
);
   logic [1:0] mac_mode_select_r;
   logic [7:0] legacy_compat_flags_r;
   logic encrypt_r;
   logic src_long_r;
   logic [7:0] app_retry_count_r;
   logic hdr_on;
   logic ack_on;
   logic legacy_on;

   assign hdr_on = (mac_mode_select_r == 2'h0) || (mac_mode_select_r == 2'h3);
   assign ack_on = (mac_mode_select_r == 2'h0) || (mac_mode_select_r == 2'h2);
   assign legacy_on = legacy_compat_flags_r[0];

   // Bus slave: zero wait states, read data prepared in the address phase.
   logic dp_wr_r;
   logic [2:0] dp_idx_r;
   logic addr_ok;
   logic [2:0] a_idx;
   logic a_take;

   assign a_idx = haddr[4:2];
   assign addr_ok = (haddr[31:5] == 27'h0) && (a_idx <= `RTPC_OFF_LIMIT);
   assign a_take = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r <= 1'b0;
         dp_idx_r <= 3'h0;
      end else if (hready) begin
         dp_wr_r <= a_take && hwrite && addr_ok;
         dp_idx_r <= a_idx;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   logic wr_ctrl;
   logic wr_retry;
   logic wr_txreq;
   logic wr_status;

   assign wr_ctrl = dp_wr_r && (dp_idx_r == `RTPC_OFF_CTRL);
   assign wr_retry = dp_wr_r && (dp_idx_r == `RTPC_OFF_RETRY);
   assign wr_txreq = dp_wr_r && (dp_idx_r == `RTPC_OFF_TXREQ);
   assign wr_status = dp_wr_r && (dp_idx_r == `RTPC_OFF_STATUS);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mac_mode_select_r <= `RTPC_RST_MODE;
         legacy_compat_flags_r <= `RTPC_RST_COMPAT;
         encrypt_r <= 1'b0;
         src_long_r <= 1'b0;
      end else if (wr_ctrl) begin
         mac_mode_select_r <= hwdata[`RTPC_CTRL_MODE_LSB +: 2];
         legacy_compat_flags_r <= hwdata[`RTPC_CTRL_COMPAT_LSB +: 8];
         encrypt_r <= hwdata[`RTPC_CTRL_ENC_BIT];
         src_long_r <= hwdata[`RTPC_CTRL_SRCLONG_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         app_retry_count_r <= `RTPC_RST_RETRY;
      end else if (wr_retry) begin
         app_retry_count_r <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dup_detect_en <= 1'b1;
      end else begin
         dup_detect_en <= hdr_on;
      end
   end

   // Request intake.
   logic [7:0] req_fid;
   logic [7:0] req_len;
   logic req_dlong;
   logic req_bcast;
   logic [7:0] req_limit;
   logic [7:0] short_limit;
   logic room;
   logic too_big;
   logic push;
   logic refuse;

   assign req_fid = hwdata[`RTPC_TXREQ_FID_LSB +: 8];
   assign req_len = hwdata[`RTPC_TXREQ_LEN_LSB +: 8];
   assign req_dlong = hwdata[`RTPC_TXREQ_DLONG_BIT];
   assign req_bcast = hwdata[`RTPC_TXREQ_BCAST_BIT];

   // Evaluated against the settings in force at the write, not at dispatch.
   rtpc_limit u_limit (
      .legacy_on(legacy_on),
      .encrypt_on(encrypt_r),
      .hdr_on(hdr_on),
      .src_long(src_long_r),
      .dest_long(req_dlong),
      .limit(req_limit)
   );

   rtpc_limit u_limit_view (
      .legacy_on(legacy_on),
      .encrypt_on(encrypt_r),
      .hdr_on(hdr_on),
      .src_long(src_long_r),
      .dest_long(1'b0),
      .limit(short_limit)
   );

   logic [7:0] q_fid [4];
   logic [7:0] q_len [4];
   logic [3:0] q_dlong;
   logic [3:0] q_bcast;
   logic [1:0] q_wp_r;
   logic [1:0] q_rp_r;
   logic [2:0] q_cnt_r;
   logic [1:0] eng_busy;
   logic [1:0] eng_req;
   logic [1:0] eng_done;
   logic [1:0] disp;
   logic both_idle;
   logic head_bcast;
   logic pop;

   assign both_idle = (eng_busy == 2'b00);
   // The legacy behaviour keeps at most one request in the whole block.
   assign room = legacy_on ? ((q_cnt_r == 3'h0) && both_idle) : (q_cnt_r < `RTPC_QDEPTH);
   assign too_big = req_len > req_limit;
   assign push = wr_txreq && !too_big && room;
   assign refuse = wr_txreq && !too_big && !room;

   assign head_bcast = q_bcast[q_rp_r];
   assign disp[0] = (q_cnt_r != 3'h0) && !head_bcast && (legacy_on ? both_idle : !eng_busy[0]);
   assign disp[1] = (q_cnt_r != 3'h0) && head_bcast && (legacy_on ? both_idle : !eng_busy[1]);
   assign pop = disp[0] || disp[1];

   always_ff @(posedge hclk) begin
      if (push) begin
         q_fid[q_wp_r] <= req_fid;
         q_len[q_wp_r] <= req_len;
         q_dlong[q_wp_r] <= req_dlong;
         q_bcast[q_wp_r] <= req_bcast;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q_wp_r <= 2'h0;
         q_rp_r <= 2'h0;
         q_cnt_r <= 3'h0;
      end else begin
         if (push) begin
            q_wp_r <= q_wp_r + 2'h1;
         end
         if (pop) begin
            q_rp_r <= q_rp_r + 2'h1;
         end
         q_cnt_r <= q_cnt_r + {2'h0, push} - {2'h0, pop};
      end
   end

   logic ovf_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_r <= 1'b0;
      end else if (refuse) begin
         ovf_r <= 1'b1;
      end else if (wr_status && hwdata[`RTPC_STAT_OVF_BIT]) begin
         ovf_r <= 1'b0;
      end
   end

   // Radio attempt arbitration, round robin between the two engines.
   logic rf_busy_r;
   logic last_gnt_r;
   logic grant_v;
   logic grant_e;
   logic [7:0] e_fid [2];
   logic [7:0] e_len [2];
   logic [7:0] e_code [2];
   logic [1:0] e_dlong;
   logic [1:0] e_ack;
   logic [1:0] e_hdr;

   assign grant_v = !rf_busy_r && (eng_req != 2'b00);
   assign grant_e = eng_req[1] && (!eng_req[0] || !last_gnt_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rf_busy_r <= 1'b0;
         last_gnt_r <= 1'b0;
      end else begin
         if (grant_v) begin
            rf_busy_r <= 1'b1;
            last_gnt_r <= grant_e;
         end else if (rf_done) begin
            rf_busy_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rf_start <= 1'b0;
         rf_tag <= 1'b0;
         rf_ack_req <= 1'b0;
         rf_app_hdr <= 1'b0;
         rf_bcast <= 1'b0;
         rf_dest_long <= 1'b0;
         rf_encrypt <= 1'b0;
         rf_len <= 8'h00;
      end else begin
         rf_start <= grant_v;
         if (grant_v) begin
            rf_tag <= grant_e;
            rf_ack_req <= e_ack[grant_e];
            rf_app_hdr <= e_hdr[grant_e];
            rf_bcast <= grant_e;
            rf_dest_long <= e_dlong[grant_e];
            rf_encrypt <= encrypt_r;
            rf_len <= e_len[grant_e];
         end
      end
   end

   // Engine 0 carries unicasts, engine 1 broadcasts; both may be in flight at once except in legacy mode.
   logic emit_v;
   logic [1:0] emit_src;
   logic rej_pend_r;
   logic [7:0] rej_fid_r;

   for (genvar e = 0; e < 2; e++) begin : g_eng
      rtpc_pkg::rtpc_eng_st_t st_r;
      logic [7:0] fid_r;
      logic [7:0] len_r;
      logic dlong_r;
      logic ack_r;
      logic hdr_r;
      logic [7:0] rr_r;
      logic [1:0] mac_r;
      logic [7:0] app_r;
      logic [7:0] code_r;
      logic mine;
      logic app_left;

      assign mine = rf_done && (rf_done_tag == e[0]) && (st_r == rtpc_pkg::ENG_WAIT);
      assign app_left = app_r < rr_r;
      assign eng_busy[e] = st_r != rtpc_pkg::ENG_IDLE;
      assign eng_req[e] = st_r == rtpc_pkg::ENG_REQ;
      assign eng_done[e] = st_r == rtpc_pkg::ENG_DONE;
      assign e_fid[e] = fid_r;
      assign e_len[e] = len_r;
      assign e_code[e] = code_r;
      assign e_dlong[e] = dlong_r;
      assign e_ack[e] = ack_r;
      assign e_hdr[e] = hdr_r;

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            st_r <= rtpc_pkg::ENG_IDLE;
            fid_r <= 8'h00;
            len_r <= 8'h00;
            dlong_r <= 1'b0;
            ack_r <= 1'b0;
            hdr_r <= 1'b0;
            rr_r <= 8'h00;
            mac_r <= 2'h0;
            app_r <= 8'h00;
            code_r <= 8'h00;
         end else begin
            case (st_r)
               rtpc_pkg::ENG_IDLE: begin
                  if (disp[e]) begin
                     fid_r <= q_fid[q_rp_r];
                     len_r <= q_len[q_rp_r];
                     dlong_r <= q_dlong[q_rp_r];
                     ack_r <= (e == 0) && ack_on;
                     hdr_r <= hdr_on;
                     rr_r <= hdr_on ? app_retry_count_r : 8'h00;
                     mac_r <= 2'h0;
                     app_r <= 8'h00;
                     st_r <= rtpc_pkg::ENG_REQ;
                  end
               end
               rtpc_pkg::ENG_REQ: begin
                  if (grant_v && (grant_e == e[0])) begin
                     st_r <= rtpc_pkg::ENG_WAIT;
                  end
               end
               rtpc_pkg::ENG_WAIT: begin
                  if (mine) begin
                     st_r <= (fid_r == 8'h00) ? rtpc_pkg::ENG_IDLE : rtpc_pkg::ENG_DONE;
                     case (rtpc_pkg::rtpc_result_t'(rf_result))
                        rtpc_pkg::RES_OK: begin
                           code_r <= `RTPC_ST_OK;
                        end
                        rtpc_pkg::RES_NOACK: begin
                           if (!ack_r) begin
                              code_r <= `RTPC_ST_OK;
                           end else if (mac_r < `RTPC_MAC_RETRIES) begin
                              mac_r <= mac_r + 2'h1;
                              st_r <= rtpc_pkg::ENG_REQ;
                           end else if (app_left) begin
                              app_r <= app_r + 8'h01;
                              mac_r <= 2'h0;
                              st_r <= rtpc_pkg::ENG_REQ;
                           end else begin
                              code_r <= (rr_r != 8'h00) ? `RTPC_ST_NETACK : `RTPC_ST_NOACK;
                           end
                        end
                        rtpc_pkg::RES_BUSY: begin
                           // Channel busy is retried even without acks requested.
                           if (mac_r < `RTPC_MAC_RETRIES) begin
                              mac_r <= mac_r + 2'h1;
                              st_r <= rtpc_pkg::ENG_REQ;
                           end else if (app_left) begin
                              app_r <= app_r + 8'h01;
                              mac_r <= 2'h0;
                              st_r <= rtpc_pkg::ENG_REQ;
                           end else begin
                              code_r <= `RTPC_ST_CCA;
                           end
                        end
                        default: begin
                           if (app_left) begin
                              app_r <= app_r + 8'h01;
                              mac_r <= 2'h0;
                              st_r <= rtpc_pkg::ENG_REQ;
                           end else begin
                              code_r <= (rr_r != 8'h00) ? `RTPC_ST_NETACK : `RTPC_ST_OK;
                           end
                        end
                     endcase
                  end
               end
               rtpc_pkg::ENG_DONE: begin
                  if (emit_v && (emit_src == (2'h1 << e))) begin
                     st_r <= rtpc_pkg::ENG_IDLE;
                  end
               end
               default: begin
                  st_r <= rtpc_pkg::ENG_IDLE;
               end
            endcase
         end
      end
   end

   // Status output: one frame per cycle; rejects first, then unicast, then broadcast.
   always_comb begin
      emit_v = rej_pend_r || (eng_done != 2'b00);
      if (rej_pend_r) begin
         emit_src = 2'h0;
      end else if (eng_done[0]) begin
         emit_src = 2'h1;
      end else begin
         emit_src = 2'h2;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rej_pend_r <= 1'b0;
         rej_fid_r <= 8'h00;
      end else if (wr_txreq && too_big && (req_fid != 8'h00)) begin
         rej_pend_r <= 1'b1;
         rej_fid_r <= req_fid;
      end else if (emit_v && (emit_src == 2'h0)) begin
         rej_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txs_valid <= 1'b0;
         txs_frame_id <= 8'h00;
         txs_code <= 8'h00;
      end else begin
         txs_valid <= emit_v;
         if (emit_v) begin
            case (emit_src)
               2'h0: begin
                  txs_frame_id <= rej_fid_r;
                  txs_code <= `RTPC_ST_TOOBIG;
               end
               2'h1: begin
                  txs_frame_id <= e_fid[0];
                  txs_code <= e_code[0];
               end
               default: begin
                  txs_frame_id <= e_fid[1];
                  txs_code <= e_code[1];
               end
            endcase
         end
      end
   end

   // Read data; unmapped addresses read as zero with an OKAY response.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (hready) begin
         hrdata <= 32'h0;
         if (a_take && !hwrite && addr_ok) begin
            case (a_idx)
               `RTPC_OFF_CTRL: hrdata <= {16'h0, legacy_compat_flags_r, 4'h0, src_long_r,
                                          encrypt_r, mac_mode_select_r};
               `RTPC_OFF_RETRY: hrdata <= {24'h0, app_retry_count_r};
               `RTPC_OFF_STATUS: hrdata <= {7'h0, ovf_r, 3'h0, q_cnt_r, eng_busy,
                                            txs_frame_id, txs_code};
               `RTPC_OFF_LIMIT: hrdata <= {24'h0, short_limit};
               default: hrdata <= 32'h0;
            endcase
         end
      end
   end
endmodule // rtpc_tx_ctrl

// file: verilog/rtpc_params.svh
// Offsets, field positions, reset values and limits of the transmit control block.
`ifndef RTPC_PARAMS_SVH
`define RTPC_PARAMS_SVH

`define RTPC_OFF_CTRL 3'h0
`define RTPC_OFF_RETRY 3'h1
`define RTPC_OFF_TXREQ 3'h2
`define RTPC_OFF_STATUS 3'h3
`define RTPC_OFF_LIMIT 3'h4

`define RTPC_CTRL_MODE_LSB 0
`define RTPC_CTRL_ENC_BIT 2
`define RTPC_CTRL_SRCLONG_BIT 3
`define RTPC_CTRL_COMPAT_LSB 8

`define RTPC_TXREQ_FID_LSB 0
`define RTPC_TXREQ_LEN_LSB 8
`define RTPC_TXREQ_DLONG_BIT 16
`define RTPC_TXREQ_BCAST_BIT 17

`define RTPC_STAT_OVF_BIT 24

`define RTPC_RST_MODE 2'h0
`define RTPC_RST_COMPAT 8'h00
`define RTPC_RST_RETRY 8'h00

`define RTPC_MAX_PAYLOAD 8'h74
`define RTPC_LEGACY_ENC 8'h5F
`define RTPC_LEGACY_PLAIN 8'h64
`define RTPC_HDR_PLAIN 8'h02
`define RTPC_HDR_ENC 8'h04
`define RTPC_LONG_ADDR 8'h06
`define RTPC_ENC_OVH 8'h05

`define RTPC_ST_OK 8'h00
`define RTPC_ST_NOACK 8'h01
`define RTPC_ST_CCA 8'h02
`define RTPC_ST_NETACK 8'h21
`define RTPC_ST_TOOBIG 8'h74

`define RTPC_MAC_RETRIES 2'h3
`define RTPC_QDEPTH 3'h4

`endif

// file: verilog/rtpc_pkg.sv
// Types shared by the transmit control block.
package rtpc_pkg;
   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_REQ = 2'b01,
      ENG_WAIT = 2'b10,
      ENG_DONE = 2'b11
   } rtpc_eng_st_t;
   typedef enum logic [1:0] {
      RES_OK = 2'b00,
      RES_NOACK = 2'b01,
      RES_BUSY = 2'b10,
      RES_APPFAIL = 2'b11
   } rtpc_result_t;
endpackage

// file: verilog/rtpc_limit.sv
// Payload limit calculator for one transmit request.
`include "rtpc_params.svh"
module rtpc_limit (
   input wire logic legacy_on,
   input wire logic encrypt_on,
   input wire logic hdr_on,
   input wire logic src_long,
   input wire logic dest_long,
   output logic [7:0] limit
);
   logic [7:0] sub;

   always_comb begin
      sub = 8'h00;
      // Encryption forces a long source address, so both penalties apply together.
      if (encrypt_on) begin
         sub = sub + `RTPC_ENC_OVH + `RTPC_LONG_ADDR;
      end else if (src_long) begin
         sub = sub + `RTPC_LONG_ADDR;
      end
      if (dest_long) begin
         sub = sub + `RTPC_LONG_ADDR;
      end
      if (hdr_on) begin
         sub = sub + (encrypt_on ? `RTPC_HDR_ENC : `RTPC_HDR_PLAIN);
      end
      if (legacy_on) begin
         limit = encrypt_on ? `RTPC_LEGACY_ENC : `RTPC_LEGACY_PLAIN;
      end else begin
         limit = `RTPC_MAX_PAYLOAD - sub;
      end
   end
endmodule // rtpc_limit

// file: tb/rtpc_tx_ctrl_assertions.sv
// Concurrent checks on the ports of the transmit control block.
module rtpc_tx_ctrl_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic rf_start,
   input wire logic rf_tag,
   input wire logic rf_ack_req,
   input wire logic rf_app_hdr,
   input wire logic rf_bcast,
   input wire logic [7:0] rf_len,
   input wire logic dup_detect_en,
   input wire logic txs_valid,
   input wire logic [7:0] txs_code
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_ph_r;
   // Read data may only stand in the data phase of a read.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ph_r <= 1'b0;
      end else begin
         rd_ph_r <= hsel & hready & htrans[1] & ~hwrite;
      end
   end
   bus_okay_a: assert property (hresp == 1'b0) else $error("error response seen");
   no_wait_a: assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
   rdata_idle_a: assert property (!rd_ph_r |-> hrdata == 32'h0) else $error("stale read data");
   bcast_noack_a: assert property (rf_start && rf_bcast |-> !rf_ack_req)
      else $error("broadcast asks for ack");
   hdr_dup_a: assert property (rf_start |-> rf_app_hdr == dup_detect_en)
      else $error("header and duplicate detection disagree");
   bcast_engine_a: assert property (rf_start |-> rf_tag == rf_bcast)
      else $error("wrong engine for packet kind");
   attr_hold_a: assert property (!rf_start |-> $stable(rf_len) && $stable(rf_ack_req))
      else $error("attempt attributes moved");
   len_cap_a: assert property (rf_start |-> rf_len <= 8'h74)
      else $error("payload above limit sent");
   code_set_a: assert property (txs_valid |->
      txs_code inside {8'h00, 8'h01, 8'h02, 8'h21, 8'h74}) else $error("unknown status code");
endmodule // rtpc_tx_ctrl_chk

bind rtpc_tx_ctrl rtpc_tx_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .rf_start(rf_start), .rf_tag(rf_tag), .rf_ack_req(rf_ack_req),
   .rf_app_hdr(rf_app_hdr), .rf_bcast(rf_bcast), .rf_len(rf_len),
   .dup_detect_en(dup_detect_en), .txs_valid(txs_valid), .txs_code(txs_code));

// file: tb/rtpc_radio_model.sv
// Behavioural radio with remote node, answering each launched attempt once.
module rtpc_radio_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic rf_start,
   input wire logic rf_tag,
   input wire logic rf_ack_req,
   input wire logic [1:0] res_cfg,
   input wire logic [4:0] dly,
   output logic rf_done,
   output logic rf_done_tag,
   output logic [1:0] rf_result
);
   logic [4:0] cnt_r [2];
   logic [1:0] res_r [2];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '{5'h00, 5'h00};
         res_r <= '{2'h0, 2'h0};
         rf_done <= 1'b0;
         rf_done_tag <= 1'b0;
         rf_result <= 2'h0;
      end else begin
         // Outside an answer rf_done stays low and the tag and result lines toggle so no stale value looks valid.
         rf_done <= 1'b0;
         rf_done_tag <= ~rf_done_tag;
         rf_result <= ~rf_result;
         for (int t = 0; t < 2; t++) begin
            if (cnt_r[t] > 5'h01) cnt_r[t] <= cnt_r[t] - 5'h01;
         end
         // Two engines finishing together: the broadcast one waits a cycle.
         if (cnt_r[0] == 5'h01) begin
            rf_done <= 1'b1;
            rf_done_tag <= 1'b0;
            rf_result <= res_r[0];
            cnt_r[0] <= 5'h00;
         end else if (cnt_r[1] == 5'h01) begin
            rf_done <= 1'b1;
            rf_done_tag <= 1'b1;
            rf_result <= res_r[1];
            cnt_r[1] <= 5'h00;
         end
         if (rf_start) begin
            cnt_r[rf_tag] <= dly;
            // A node that was not asked for an ack never sends one.
            res_r[rf_tag] <= (!rf_ack_req && res_cfg == 2'h0) ? 2'h1 : res_cfg;
         end
      end
   end
endmodule // rtpc_radio_model

// file: tb/rf_tx_payload_ack_retry_ctrl_tb.sv
// Self-checking bench for the transmit control block.
module rf_tx_payload_ack_retry_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, res_cfg, rf_result;
   logic [2:0] hsize;
   logic rf_start, rf_tag, rf_ack_req, rf_app_hdr, rf_bcast, rf_dest_long, rf_encrypt;
   logic rf_done, rf_done_tag, dup_detect_en, txs_valid, last_ack, last_hdr;
   logic [7:0] rf_len, txs_frame_id, txs_code;
   logic [4:0] dly;
   logic [1:0] last_de;
   logic [15:0] stq [$];
   int bad_count, num_checks, n_starts;
   localparam logic [19:0] LIM_TAB [10] = '{20'h00072, 20'h0086C, 20'h00174, 20'h0096E,
      20'h00465, 20'h00C65, 20'h00569, 20'h10064, 20'h1045F, 20'h10D5F};
   assign hready = hreadyout;
   rtpc_tx_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rf_start(rf_start),
      .rf_tag(rf_tag), .rf_ack_req(rf_ack_req), .rf_app_hdr(rf_app_hdr), .rf_bcast(rf_bcast),
      .rf_dest_long(rf_dest_long), .rf_encrypt(rf_encrypt), .rf_len(rf_len),
      .rf_done(rf_done), .rf_done_tag(rf_done_tag), .rf_result(rf_result),
      .dup_detect_en(dup_detect_en), .txs_valid(txs_valid), .txs_frame_id(txs_frame_id),
      .txs_code(txs_code));
   rtpc_radio_model u_radio (.hclk(hclk), .hresetn(hresetn), .rf_start(rf_start),
      .rf_tag(rf_tag), .rf_ack_req(rf_ack_req), .res_cfg(res_cfg), .dly(dly),
      .rf_done(rf_done), .rf_done_tag(rf_done_tag), .rf_result(rf_result));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(negedge hclk) begin
      if (rf_start === 1'b1) begin
         n_starts++;
         last_ack = rf_ack_req;
         last_hdr = rf_app_hdr;
         last_de = {rf_encrypt, rf_dest_long};
      end
      if (txs_valid === 1'b1) stq.push_back({txs_frame_id, txs_code});
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Ready and read data are read at the rising edge, before that edge's updates land.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      @(posedge hclk);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic send(input logic [7:0] fid, input logic [7:0] len, input logic dl,
                       input logic bc);
      bus(1'b1, 32'h08, {14'h0, bc, dl, len, fid});
   endtask
   task automatic exp_txs(input logic [7:0] fid, input logic [7:0] code);
      int n;
      n = 0;
      while (stq.size() == 0 && n < 400) begin
         @(posedge hclk);
         n++;
      end
      if (stq.size() == 0) stq.push_back(16'hFFFF);
      chk(stq.pop_front(), {fid, code});
   endtask
   task automatic run(input logic [31:0] ctrl, input logic [7:0] rr, input logic [1:0] res,
                      input logic [7:0] code, input int nst);
      bus(1'b1, 32'h00, ctrl);
      bus(1'b1, 32'h04, {24'h0, rr});
      res_cfg <= res;
      n_starts = 0;
      send(8'h11, 8'h0A, 1'b0, 1'b0);
      exp_txs(8'h11, code);
      chk(n_starts, nst);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans, res_cfg} = '0;
      hsize = 3'h2;
      dly = 5'h03;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      chk(dup_detect_en, 1'b1);
      rd_chk(32'h00, 32'h0);
      rd_chk(32'h1C, 32'h0);
      rd_chk(32'h08, 32'h0);
      foreach (LIM_TAB[i]) begin
         bus(1'b1, 32'h00, {20'h0, LIM_TAB[i][19:8]});
         rd_chk(32'h10, {24'h0, LIM_TAB[i][7:0]});
      end
      rd_chk(32'h00, 32'h10D);
      for (int m = 0; m < 4; m++) begin
         run({30'h0, m[1:0]}, 8'h00, 2'h0, 8'h00, 1);
         chk(last_ack, m == 0 || m == 2);
         chk(last_hdr, m == 0 || m == 3);
         chk(dup_detect_en, m == 0 || m == 3);
      end
      run(32'h0, 8'h00, 2'h1, 8'h01, 4);
      run(32'h1, 8'h00, 2'h2, 8'h02, 4);
      run(32'h0, 8'h02, 2'h1, 8'h21, 12);
      run(32'h2, 8'h02, 2'h1, 8'h01, 4);
      run(32'h3, 8'h02, 2'h3, 8'h21, 3);
      run(32'h8, 8'h00, 2'h0, 8'h00, 1);
      n_starts = 0;
      send(8'h21, 8'h67, 1'b1, 1'b0);
      exp_txs(8'h21, 8'h74);
      send(8'h00, 8'h67, 1'b1, 1'b0);
      send(8'h22, 8'h66, 1'b1, 1'b0);
      exp_txs(8'h22, 8'h00);
      chk(n_starts, 1);
      chk(last_de, 2'h1);
      dly <= 5'h14;
      for (int lg = 0; lg < 2; lg++) begin
         bus(1'b1, 32'h00, {23'h0, lg[0], 8'h0});
         n_starts = 0;
         send(8'h31, 8'h0A, 1'b0, 1'b0);
         send(8'h32, 8'h0A, 1'b0, 1'b1);
         // One radio serves both engines, so concurrency shows as two busy engines.
         bus(1'b0, 32'h0C, 32'h0);
         chk(rd[24], lg[0]);
         chk(rd[17:16], lg ? 2'h1 : 2'h3);
         exp_txs(8'h31, 8'h00);
         if (lg == 0) exp_txs(8'h32, 8'h00);
         chk(n_starts, 2 - lg);
         if (lg == 0) chk(last_ack, 1'b0);
      end
      bus(1'b1, 32'h0C, 32'h0100_0000);
      rd_chk(32'h0C, 32'h0000_3100);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      rd_chk(32'h00, 32'h0);
      conclude();
   end
   initial begin
      #300000;
      bad_count++;
      conclude();
   end
endmodule // rf_tx_payload_ack_retry_ctrl_tb
